/* design/tc_pkg.sv */
// Purpose: shared constants and types for the timer/counter engine.
// Assumes: 50 MHz reference clock, Avalon-MM register slave with byte addresses.
// Notes: present values are kept in binary inside the engine.
package tc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_1MS_NS = 1000000;
    localparam int TICK_1MS_CYC = (TICK_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] DECADE_LAST = 4'h9;
    localparam int UNITS = 3;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CMD = 5'h00;
    localparam logic [4:0] ADDR_SV = 5'h04;
    localparam logic [4:0] ADDR_IND = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0C;
    localparam logic [4:0] ADDR_RESULT = 5'h10;
    localparam logic [31:0] CMD_RESET = 32'h00000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_BCD_BIT = 2;

    // ------------------------------------------------------------
    // instruction kinds
    // ------------------------------------------------------------
    localparam logic [2:0] KIND_HUNDRED = 3'h0;
    localparam logic [2:0] KIND_TEN = 3'h1;
    localparam logic [2:0] KIND_ONE = 3'h2;
    localparam logic [2:0] KIND_ACCUM = 3'h3;
    localparam logic [2:0] KIND_LONG = 3'h4;
    localparam logic [2:0] KIND_COUNTER = 3'h5;
    localparam logic [2:0] KIND_RESET_OP = 3'h6;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [15:0] PV_RESET_BIN = 16'hFFFF;
    localparam logic [15:0] PV_RESET_BCD = 16'h270F;
    localparam logic [15:0] PV_ZERO = 16'h0000;
    localparam logic [15:0] PV_ONE = 16'h0001;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] spare_hi;
        logic [7:0] index;
        logic [6:0] spare_lo;
        logic indirect;
        logic interlocked;
        logic jumped;
        logic reset_in;
        logic exec_in;
        logic bcd;
        logic [2:0] kind;
    } cmd_t;

    typedef struct packed {
        logic [2:0] kind;
        logic prev_in;
        logic done;
        logic [15:0] snap;
        logic [15:0] pv;
    } entry_t;

    localparam int ENTRY_W = $bits(entry_t);

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD = 4'h2,
        ST_EXEC = 4'h4,
        ST_ACK = 4'h8
    } fsm_t;

endpackage

/* design/tc_entry_ram.sv */
// Purpose: per-entry state store for timers and counters.
// Assumes: single port, one read every cycle plus an optional write.
// Notes: contents carry no reset so counter values survive a reset.
`timescale 1ns/1ps
module tc_entry_ram #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic ref_clk, // clock
    input wire logic [AW-1:0] addr, // entry index
    input wire logic wr_en, // write strobe
    input wire logic [WIDTH-1:0] wr_data, // entry to store
    output logic [WIDTH-1:0] rd_data_r // registered read data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // synchronous write and registered read
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data_r <= mem[addr];
    end

endmodule

/* design/tc_core.sv */
// Purpose: timer and counter engine run one instruction at a time from software.
// Assumes: software issues each instruction as a write to the command register.
// Notes: elapsed time is measured against free-running unit counters, so a timer
//        keeps timing between executions and only its stored value lags.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

// Functional notes
// - BCD variant reads set value as digits
// - binary variant reads 16-bit unsigned set value
// - indirect set value decoded same way
// - each instruction's variant alone picks encoding
// - short timers update only when executed
// - reset op loads FFFF or 9999, clears flag, except on accumulative entries
// - jump: short timers run, others hold
// - interlock: PV=SV flag off, accumulative and counter hold
// - counter value kept across reset
// - counter reset input reloads set value
// - input low holds SV, high counts down
module tc_core #(
    parameter int TICK_CYC = tc_pkg::TICK_1MS_CYC,
    parameter int ENTRIES = 256
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest // stall
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] bcd2bin(input logic [15:0] v);
        return 16'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
    endfunction

    function automatic logic [15:0] bin2bcd(input logic [15:0] v);
        logic [31:0] sh;
        int i;
        int j;
        sh = {16'h0000, v};
        for (i = 0; i < 16; i++) begin
            for (j = 0; j < 4; j++) begin
                if (sh[16 + 4 * j +: 4] > 4'h4) begin
                    sh[16 + 4 * j +: 4] = sh[16 + 4 * j +: 4] + 4'h3;
                end
            end
            sh = sh << 1;
        end
        return sh[31:16];
    endfunction

    // ------------------------------------------------------------
    // time base: 1 ms, 10 ms and 100 ms unit counters
    // ------------------------------------------------------------
    localparam int UNITS_HI = tc_pkg::UNITS;
    logic [15:0] base_cnt_r;
    wire [UNITS_HI:0] tick;
    wire [15:0] now_bus [tc_pkg::UNITS];
    wire base_wrap = (base_cnt_r == 16'(TICK_CYC - 1));
    assign tick[0] = base_wrap;

    // prescaler to the 1 ms tick
    always_ff @(posedge ref_clk) begin
        if (rst || base_wrap) begin
            base_cnt_r <= 16'h0000;
        end else begin
            base_cnt_r <= base_cnt_r + 16'h0001;
        end
    end

    // one decade stage and free-running count per unit
    for (genvar u = 0; u < tc_pkg::UNITS; u++) begin : g_unit
        logic [3:0] dec_r;
        logic [15:0] now_r;
        assign tick[u + 1] = tick[u] && (dec_r == tc_pkg::DECADE_LAST);
        assign now_bus[u] = now_r;
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                dec_r <= 4'h0;
                now_r <= 16'h0000;
            end else if (tick[u]) begin
                dec_r <= (dec_r == tc_pkg::DECADE_LAST) ? 4'h0 : dec_r + 4'h1;
                now_r <= now_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    tc_pkg::fsm_t state_r;
    tc_pkg::cmd_t cmd_r;
    wire [31:0] sv_word;
    wire [31:0] ind_word;
    logic [15:0] result_r;
    logic done_r;
    logic err_r;
    logic [ENTRIES-1:0] valid_r;
    logic [31:0] readdata_r;
    logic waitrequest_r;
    wire idle = (state_r == tc_pkg::ST_IDLE);
    wire req = avs_read || avs_write;
    wire cmd_we = idle && avs_write && (avs_address == tc_pkg::ADDR_CMD);
    wire sv_we = idle && avs_write && (avs_address == tc_pkg::ADDR_SV);
    wire ind_we = idle && avs_write && (avs_address == tc_pkg::ADDR_IND);
    wire [31:0] status_word = {29'h00000000, cmd_r.bcd, err_r, done_r};

    // read selection, unmapped addresses read as zero
    wire [31:0] rd_word =
        (avs_address == tc_pkg::ADDR_CMD) ? 32'(cmd_r) :
        (avs_address == tc_pkg::ADDR_SV) ? sv_word :
        (avs_address == tc_pkg::ADDR_IND) ? ind_word :
        (avs_address == tc_pkg::ADDR_STATUS) ? status_word :
        (avs_address == tc_pkg::ADDR_RESULT) ? {16'h0000, result_r} : 32'h00000000;

    // byte-lane writes of set value and indirect word
    for (genvar b = 0; b < 4; b++) begin : g_byte
        logic [7:0] sv_byte_r;
        logic [7:0] ind_byte_r;
        assign sv_word[8 * b +: 8] = sv_byte_r;
        assign ind_word[8 * b +: 8] = ind_byte_r;
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                sv_byte_r <= tc_pkg::BYTE_RESET;
                ind_byte_r <= tc_pkg::BYTE_RESET;
            end else begin
                if (sv_we && avs_byteenable[b]) sv_byte_r <= avs_writedata[8 * b +: 8];
                if (ind_we && avs_byteenable[b]) ind_byte_r <= avs_writedata[8 * b +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // entry store
    // ------------------------------------------------------------
    logic [tc_pkg::ENTRY_W-1:0] ram_rd;
    tc_pkg::entry_t nxt;
    wire tc_pkg::entry_t ent = tc_pkg::entry_t'(ram_rd);
    wire exec_now = (state_r == tc_pkg::ST_EXEC);

    tc_entry_ram #(
        .WIDTH(tc_pkg::ENTRY_W),
        .DEPTH(ENTRIES),
        .AW(8)
    ) u_ram (
        .ref_clk(ref_clk),
        .addr(cmd_r.index),
        .wr_en(exec_now),
        .wr_data(nxt),
        .rd_data_r(ram_rd)
    );

    // ------------------------------------------------------------
    // set value decode
    // ------------------------------------------------------------
    wire [15:0] raw_sv = cmd_r.indirect ? ind_word[15:0] : sv_word[15:0];
    wire bcd_ok = (raw_sv[15:12] <= tc_pkg::BCD_DIGIT_MAX) && (raw_sv[11:8] <= tc_pkg::BCD_DIGIT_MAX) &&
        (raw_sv[7:4] <= tc_pkg::BCD_DIGIT_MAX) && (raw_sv[3:0] <= tc_pkg::BCD_DIGIT_MAX);
    wire [15:0] sv_val = cmd_r.bcd ? bcd2bin(raw_sv) : raw_sv;
    wire sv_bad = cmd_r.bcd && !bcd_ok;

    // ------------------------------------------------------------
    // execution datapath
    // ------------------------------------------------------------
    wire is_dec = (cmd_r.kind == tc_pkg::KIND_HUNDRED) || (cmd_r.kind == tc_pkg::KIND_TEN) ||
        (cmd_r.kind == tc_pkg::KIND_ONE) || (cmd_r.kind == tc_pkg::KIND_LONG);
    wire is_timer = is_dec || (cmd_r.kind == tc_pkg::KIND_ACCUM);
    wire fresh = is_timer && !valid_r[cmd_r.index];
    wire [1:0] unit_sel = (cmd_r.kind == tc_pkg::KIND_ONE) ? 2'h0 : (cmd_r.kind == tc_pkg::KIND_TEN) ? 2'h1 : 2'h2;
    wire [15:0] now_val = now_bus[unit_sel];
    wire [15:0] init_pv = (cmd_r.kind == tc_pkg::KIND_ACCUM) ? tc_pkg::PV_ZERO : sv_val;
    // a timer never run since reset starts from its set value, or from zero if accumulative
    wire tc_pkg::entry_t cur = fresh ? {cmd_r.kind, 1'b0, 1'b0, now_val, init_pv} : ent;
    wire [15:0] elapsed = now_val - cur.snap;
    wire dec_in = cmd_r.jumped ? cur.prev_in : cmd_r.exec_in;
    wire [15:0] dec_base = cur.prev_in ? cur.pv : sv_val;
    wire [15:0] dec_el = cur.prev_in ? elapsed : tc_pkg::PV_ZERO;
    wire [15:0] dec_pv = (dec_base > dec_el) ? dec_base - dec_el : tc_pkg::PV_ZERO;
    wire [16:0] acc_sum = {1'b0, cur.pv} + {1'b0, (cur.prev_in ? elapsed : tc_pkg::PV_ZERO)};
    wire [15:0] acc_pv = (acc_sum >= {1'b0, sv_val}) ? sv_val : acc_sum[15:0];
    wire cnt_rise = cmd_r.exec_in && !cur.prev_in;
    wire [15:0] cnt_pv = (cnt_rise && (cur.pv != tc_pkg::PV_ZERO)) ? cur.pv - tc_pkg::PV_ONE : cur.pv;

    // next entry state for the instruction being executed
    always_comb begin
        nxt = cur;
        nxt.kind = cmd_r.kind;
        if (cmd_r.kind == tc_pkg::KIND_RESET_OP) begin
            nxt = ent;
            if (ent.kind != tc_pkg::KIND_ACCUM) begin
                nxt.pv = cmd_r.bcd ? tc_pkg::PV_RESET_BCD : tc_pkg::PV_RESET_BIN;
                nxt.done = 1'b0;
            end
        end else if (sv_bad) begin
            nxt = cur;
        end else if (is_dec) begin
            nxt.snap = now_val;
            if (cmd_r.interlocked) begin
                nxt.pv = sv_val;
                nxt.done = 1'b0;
                nxt.prev_in = 1'b0;
            end else if (cmd_r.jumped && (cmd_r.kind == tc_pkg::KIND_LONG)) begin
                nxt.pv = cur.pv;
                nxt.done = cur.done;
            end else if (!dec_in) begin
                nxt.pv = sv_val;
                nxt.done = 1'b0;
                nxt.prev_in = 1'b0;
            end else begin
                nxt.pv = dec_pv;
                nxt.done = (dec_pv == tc_pkg::PV_ZERO);
                nxt.prev_in = 1'b1;
            end
        end else if (cmd_r.kind == tc_pkg::KIND_ACCUM) begin
            nxt.snap = now_val;
            if (cmd_r.interlocked || cmd_r.jumped) begin
                nxt.prev_in = 1'b0;
            end else if (cmd_r.reset_in) begin
                nxt.pv = tc_pkg::PV_ZERO;
                nxt.done = 1'b0;
                nxt.prev_in = 1'b0;
            end else begin
                nxt.pv = cmd_r.exec_in ? acc_pv : cur.pv;
                nxt.done = cmd_r.exec_in ? (acc_pv >= sv_val) : cur.done;
                nxt.prev_in = cmd_r.exec_in;
            end
        end else if (cmd_r.kind == tc_pkg::KIND_COUNTER) begin
            if (cmd_r.interlocked || cmd_r.jumped) begin
                nxt.pv = cur.pv;
            end else if (cmd_r.reset_in) begin
                nxt.pv = sv_val;
                nxt.done = 1'b0;
                nxt.prev_in = cmd_r.exec_in;
            end else begin
                nxt.pv = cnt_pv;
                nxt.done = (cnt_pv == tc_pkg::PV_ZERO);
                nxt.prev_in = cmd_r.exec_in;
            end
        end else begin
            nxt = ent;
        end
    end

    wire [15:0] shown_pv = cmd_r.bcd ? bin2bcd(nxt.pv) : nxt.pv;

    // ------------------------------------------------------------
    // control sequence
    // ------------------------------------------------------------
    // command register and bus state machine
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= tc_pkg::ST_IDLE;
            cmd_r <= tc_pkg::cmd_t'(tc_pkg::CMD_RESET);
            readdata_r <= 32'h00000000;
            waitrequest_r <= 1'b1;
        end else begin
            case (state_r)
                tc_pkg::ST_IDLE: begin
                    if (cmd_we) begin
                        cmd_r <= tc_pkg::cmd_t'(avs_writedata);
                        state_r <= tc_pkg::ST_RD;
                    end else if (req) begin
                        readdata_r <= avs_read ? rd_word : 32'h00000000;
                        waitrequest_r <= 1'b0;
                        state_r <= tc_pkg::ST_ACK;
                    end
                end
                tc_pkg::ST_RD: begin
                    state_r <= tc_pkg::ST_EXEC;
                end
                tc_pkg::ST_EXEC: begin
                    waitrequest_r <= 1'b0;
                    state_r <= tc_pkg::ST_ACK;
                end
                tc_pkg::ST_ACK: begin
                    waitrequest_r <= 1'b1;
                    state_r <= tc_pkg::ST_IDLE;
                end
                default: begin
                    waitrequest_r <= 1'b1;
                    state_r <= tc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // results of the last execution and timers seen since reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_r <= tc_pkg::PV_ZERO;
            done_r <= 1'b0;
            err_r <= 1'b0;
            valid_r <= '0;
        end else if (exec_now) begin
            result_r <= shown_pv;
            done_r <= nxt.done;
            err_r <= sv_bad && (cmd_r.kind != tc_pkg::KIND_RESET_OP);
            if (is_timer && !sv_bad) valid_r[cmd_r.index] <= 1'b1;
        end
    end

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = waitrequest_r;

endmodule

/* tb/tc_core_props.sv */
// Purpose: port-level checks on the timer/counter engine and its register slave.
// Assumes: one clock, synchronous active-high reset, one outstanding access.
// Notes: attached by bind from the bench top file.
`timescale 1ns/1ps
module tc_core_props #(
    parameter int TICK_CYC = 50
) (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [4:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest // stall
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic last_bcd_r;
    wire ack = !avs_waitrequest;
    wire rd_ack = ack && avs_read;
    wire mapped = (avs_address[1:0] == 2'h0) && (avs_address <= 5'h10);
    wire st_rd = rd_ack && (avs_address == tc_pkg::ADDR_STATUS);
    wire res_rd = rd_ack && (avs_address == tc_pkg::ADDR_RESULT);

    // variant bit of the last command accepted
    always_ff @(posedge ref_clk) begin
        if (rst) last_bcd_r <= 1'b0;
        else if (ack && avs_write && avs_address == tc_pkg::ADDR_CMD) last_bcd_r <= avs_writedata[3];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_cmd_taken;
        $rose(avs_write) && avs_address == tc_pkg::ADDR_CMD;
    endsequence
    sequence s_exec_wait;
        avs_waitrequest [*3] ##1 !avs_waitrequest;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_idle_bus: assert property (disable iff (1'b0) rst |=> avs_waitrequest && avs_readdata == 32'h00000000)
        else $error("bus not idle after reset");
    a_ack_single: assert property (ack |=> avs_waitrequest)
        else $error("acknowledge longer than one cycle");
    a_ack_needs_req: assert property (ack |-> avs_read || avs_write)
        else $error("acknowledge without request");
    a_plain_fast: assert property (($rose(avs_read) || $rose(avs_write)) && avs_address != tc_pkg::ADDR_CMD |=> ack)
        else $error("register access not answered next cycle");
    a_cmd_ack_lat: assert property (s_cmd_taken |-> s_exec_wait)
        else $error("command not answered in three cycles");
    a_unmapped_zero: assert property (rd_ack && !mapped |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_status_variant: assert property (st_rd |-> avs_readdata[2] == last_bcd_r && avs_readdata[31:3] == 29'h0)
        else $error("status variant bit wrong");
    a_bin_no_err: assert property (st_rd && !last_bcd_r |-> !avs_readdata[1])
        else $error("binary command flagged a code error");
    a_bcd_digits: assert property (res_rd && last_bcd_r |-> avs_readdata[3:0] <= 4'h9 && avs_readdata[7:4] <= 4'h9
        && avs_readdata[11:8] <= 4'h9 && avs_readdata[15:12] <= 4'h9)
        else $error("decimal result holds a non-decimal digit");
    a_result_16bit: assert property (res_rd |-> avs_readdata[31:16] == 16'h0000)
        else $error("result wider than 16 bits");
endmodule

/* tb/tc_core_tb.sv */
// Purpose: self-checking bench for the timer/counter engine over its register bus.
// Assumes: one time unit shortened to TICK cycles.
// Notes: expected values follow from set values and elapsed units.
`timescale 1ns/1ps
module tc_core_tb;
    localparam int TICK = 50;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] st;
    logic [31:0] rs;
    logic [2:0] kk;
    logic [7:0] xx;
    logic bb;
    int unit_ms [3] = '{100, 10, 1};

    tc_core #(.TICK_CYC(TICK), .ENTRIES(256)) dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100) begin
            fail_count++;
            $display("bus access not answered at t=%0t", $time);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h00000000, 4'hF, q);
    endtask

    // flags f: 0 bcd, 1 input, 2 reset input, 3 jumped, 4 interlocked, 5 indirect
    function automatic logic [31:0] mk(input logic [2:0] k, input logic [5:0] f, input logic [7:0] x);
        tc_pkg::cmd_t c;
        c = '{spare_hi: 8'h00, index: x, spare_lo: 7'h00, indirect: f[5], interlocked: f[4], jumped: f[3],
            reset_in: f[2], exec_in: f[1], bcd: f[0], kind: k};
        return c;
    endfunction

    // run one instruction, then compare status and result
    task automatic exec(input logic [31:0] c, input logic [31:0] es, input logic [31:0] er);
        wr(tc_pkg::ADDR_CMD, c);
        rd(tc_pkg::ADDR_STATUS, st);
        chk(st, es);
        rd(tc_pkg::ADDR_RESULT, rs);
        chk(rs, er);
    endtask

    task automatic wait_ms(input int n);
        repeat (n * TICK) @(posedge ref_clk);
    endtask

    // watchdog
    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        $display("run did not finish in time");
        test_done();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            kk = 3'(k);
            xx = 8'(k + 1);
            bb = (k == 1);
            wr(tc_pkg::ADDR_SV, 32'h00000003);
            exec(mk(kk, 6'h00, xx), 32'h0, 32'h3);
            exec(mk(kk, 6'h02, xx), 32'h0, 32'h3);
            wait_ms(unit_ms[k] * 5);
            exec(mk(kk, 6'h02, xx), 32'h1, 32'h0);
            exec(mk(3'h6, {5'h00, bb}, xx), {29'h0, bb, 2'h0}, bb ? 32'h9999 : 32'hFFFF);
        end
        $display("test short timers done");
        wr(tc_pkg::ADDR_SV, 32'h00000012);
        exec(mk(3'h2, 6'h01, 8'h0A), 32'h4, 32'h12);
        wr(tc_pkg::ADDR_SV, 32'h0000001A);
        wr(tc_pkg::ADDR_CMD, mk(3'h2, 6'h01, 8'h0A));
        rd(tc_pkg::ADDR_STATUS, st);
        chk(st & 32'h6, 32'h6);
        wr(tc_pkg::ADDR_IND, 32'h00000034);
        exec(mk(3'h2, 6'h21, 8'h0A), 32'h4, 32'h34);
        wr(tc_pkg::ADDR_IND, 32'h00000100);
        exec(mk(3'h2, 6'h20, 8'h0B), 32'h0, 32'h100);
        wr(tc_pkg::ADDR_SV, 32'h0000FFFF);
        exec(mk(3'h2, 6'h00, 8'h0B), 32'h0, 32'hFFFF);
        $display("test encodings done");
        wr(tc_pkg::ADDR_SV, 32'h00000005);
        exec(mk(3'h1, 6'h02, 8'h14), 32'h0, 32'h5);
        wait_ms(20);
        exec(mk(3'h1, 6'h12, 8'h14), 32'h0, 32'h5);
        wr(tc_pkg::ADDR_SV, 32'h00000003);
        exec(mk(3'h2, 6'h02, 8'h17), 32'h0, 32'h3);
        wait_ms(6);
        exec(mk(3'h2, 6'h0A, 8'h17), 32'h1, 32'h0);
        exec(mk(3'h4, 6'h02, 8'h16), 32'h0, 32'h3);
        wait_ms(200);
        exec(mk(3'h4, 6'h0A, 8'h16), 32'h0, 32'h3);
        wr(tc_pkg::ADDR_SV, 32'h00000002);
        exec(mk(3'h3, 6'h04, 8'h15), 32'h0, 32'h0);
        exec(mk(3'h3, 6'h02, 8'h15), 32'h0, 32'h0);
        wait_ms(300);
        exec(mk(3'h3, 6'h02, 8'h15), 32'h1, 32'h2);
        exec(mk(3'h3, 6'h12, 8'h15), 32'h1, 32'h2);
        exec(mk(3'h3, 6'h0A, 8'h15), 32'h1, 32'h2);
        exec(mk(3'h3, 6'h04, 8'h15), 32'h0, 32'h0);
        $display("test sections done");
        wr(tc_pkg::ADDR_SV, 32'h00000003);
        exec(mk(3'h5, 6'h04, 8'h1E), 32'h0, 32'h3);
        exec(mk(3'h5, 6'h02, 8'h1E), 32'h0, 32'h2);
        exec(mk(3'h5, 6'h00, 8'h1E), 32'h0, 32'h2);
        exec(mk(3'h5, 6'h02, 8'h1E), 32'h0, 32'h1);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        exec(mk(3'h5, 6'h00, 8'h1E), 32'h0, 32'h1);
        wr(tc_pkg::ADDR_SV, 32'h00000003);
        exec(mk(3'h5, 6'h04, 8'h1E), 32'h0, 32'h3);
        exec(mk(3'h2, 6'h02, 8'h03), 32'h0, 32'h3);
        $display("test counter retention done");
        rd(5'h14, rs);
        chk(rs, 32'h00000000);
        wr(5'h14, 32'hFFFFFFFF);
        rd(5'h14, rs);
        chk(rs, 32'h00000000);
        wr(tc_pkg::ADDR_SV, 32'h00001234);
        bus(1'b1, tc_pkg::ADDR_SV, 32'h0000ABCD, 4'h1, rs);
        rd(tc_pkg::ADDR_SV, rs);
        chk(rs & 32'h0000FFFF, 32'h000012CD);
        $display("test bus map done");
        test_done();
    end
endmodule

bind tc_core tc_core_props #(.TICK_CYC(TICK_CYC)) u_props (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
